// [verif/nasc_csr_asserts.sv]
// Checker: bus answer, ROM strobes, LED pin and interrupt pulses
`timescale 1ns/1ps
module nasc_csr_asserts (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic        tx_ok,
   input  wire logic        four_led_mode,
   input  wire logic [17:0] rom_addr,
   input  wire logic        rom_rd_en,
   input  wire logic        rom_wr_en,
   input  wire logic        rom_address_bit16,
   input  wire logic        led_fd_col,
   input  wire logic        tx_done_irq,
   input  wire logic        tx_defer_irq
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   a_rd_clears: assert property ($rose(rom_rd_en) |-> ##[1:8] !rom_rd_en)
      else $error("read strobe never clears");
   a_wr_five: assert property ($rose(rom_wr_en) |-> rom_wr_en[*5] ##1 !rom_wr_en)
      else $error("write strobe length wrong");
   a_led_mode: assert property (!four_led_mode[*4] |-> led_fd_col && !rom_address_bit16)
      else $error("pin not in LED function");
   a_a16_excl: assert property (rom_address_bit16 |-> !led_fd_col)
      else $error("pin in two functions");
   a_a16_addr: assert property (rom_address_bit16 && $stable(rom_addr) |-> rom_addr[16])
      else $error("address bit 16 pin wrong");
   a_done_pulse: assert property (tx_done_irq |=> !tx_done_irq)
      else $error("done pulse too long");
   a_done_cause: assert property (tx_done_irq |-> $past(tx_ok, 2) || $past(tx_ok, 3) || $past(tx_ok, 4))
      else $error("done pulse without transmission");
   a_defer_once: assert property (tx_defer_irq |=> !tx_defer_irq[*8])
      else $error("deferral pulse repeats");
endmodule
bind nasc_csr nasc_csr_asserts i_chk (.hclk, .hresetn, .hreadyout, .hresp, .tx_ok,
   .four_led_mode, .rom_addr, .rom_rd_en, .rom_wr_en, .rom_address_bit16, .led_fd_col,
   .tx_done_irq, .tx_defer_irq);

// [verif/nic_aux_status_config_csrs_tb.sv]
// Testbench: aux status/config register bank over AHB-Lite
`timescale 1ns/1ps
module nic_aux_status_config_csrs_tb;
   import nasc_pkg::*;
   localparam int T10 = 40;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] tx_desc_ptr_now = 32'h0;
   logic [31:0] rx_desc_ptr_now = 32'h0;
   logic [2:0]  rx_state = 3'h0;
   logic        tx_ok = 1'b0;
   logic        tx_start = 1'b0;
   logic        speed_100 = 1'b0;
   logic        four_led_mode = 1'b0;
   logic        ee_valid = 1'b0;
   logic [47:0] ee_station = 48'h0;
   logic [7:0]  rom_rdata = 8'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, rom_rd_en, rom_wr_en, rom_address_bit16, led_fd_col;
   logic        tx_done_irq, tx_defer_irq;
   logic [17:0] rom_addr;
   logic [7:0]  rom_wdata;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          n_done = 0;
   int          n_defer = 0;
   nasc_csr #(.TICK10_CYC(T10)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .tx_desc_ptr_now, .rx_desc_ptr_now, .rx_state, .tx_ok, .tx_start, .speed_100,
      .four_led_mode, .ee_valid, .ee_station, .rom_rdata, .rom_addr, .rom_wdata, .rom_rd_en,
      .rom_wr_en, .rom_address_bit16, .led_fd_col, .tx_done_irq, .tx_defer_irq);
   always #10 hclk = ~hclk;
   always @(posedge hclk) begin
      n_done = n_done + (tx_done_irq === 1'b1);
      n_defer = n_defer + (tx_defer_irq === 1'b1);
   end
   // ------------------------------------------------------------
   // Bus and helper tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rdq(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      rdq(a, q);
      chk(q, e);
   endtask
   task automatic poll(input int b, output logic [31:0] q);
      int i = 0;
      rdq(NASC_OFS_ROM, q);
      while (q[b] !== 1'b0 && i < 30) begin
         rdq(NASC_OFS_ROM, q);
         i++;
      end
   endtask
   task automatic restart(output int n);
      tx_start <= 1'b0;
      cyc(4);
      tx_start <= 1'b1;
      n = 0;
      while (tx_defer_irq !== 1'b1 && n < 600) begin
         @(posedge hclk);
         n++;
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd(NASC_OFS_ROM, NASC_ROM_RESET);
      rd(NASC_OFS_BURST, NASC_BURST_RESET);
      wr(8'hf0, 32'hffff_ffff);
      rd(8'hf0, NASC_ZERO);
      chk({31'h0, led_fd_col}, 32'h1);
      $display("test reset done");
   endtask
   task automatic t_desc;
      tx_desc_ptr_now <= 32'hdead_0010;
      rx_desc_ptr_now <= 32'h1234_5670;
      cyc(4);
      rd(NASC_OFS_TXDESC, 32'hdead_0010);
      rd(NASC_OFS_RXDESC, 32'h1234_5670);
      wr(NASC_OFS_TXDESC, 32'h0);
      rd(NASC_OFS_TXDESC, 32'hdead_0010);
      $display("test descriptors done");
   endtask
   task automatic t_station;
      ee_station <= 48'h6655_4433_2211;
      ee_valid <= 1'b1;
      cyc(6);
      ee_valid <= 1'b0;
      rd(NASC_OFS_STA_LO, 32'h4433_2211);
      rd(NASC_OFS_STA_HI, 32'h0000_6655);
      rx_state <= 3'h1;
      cyc(4);
      wr(NASC_OFS_STA_LO, 32'haaaa_aaaa);
      rd(NASC_OFS_STA_LO, 32'h4433_2211);
      rx_state <= NASC_RX_STOPPED;
      cyc(4);
      wr(NASC_OFS_STA_LO, 32'h0102_0304);
      rd(NASC_OFS_STA_LO, 32'h0102_0304);
      wr(NASC_OFS_STA_HI, 32'hffff_a5c3);
      rd(NASC_OFS_STA_HI, 32'h0000_a5c3);
      $display("test station address done");
   endtask
   task automatic t_rom;
      logic [31:0] q;
      rom_rdata <= 8'h5a;
      wr(NASC_OFS_ROM, 32'h0a34_5600);
      cyc(1);
      chk({13'h0, rom_rd_en, rom_addr}, {13'h0, 1'b1, 18'h2_3456});
      poll(NASC_ROM_RD, q);
      chk(q, 32'h0234_565a);
      wr(NASC_OFS_ROM, 32'h0500_00c3);
      cyc(1);
      chk({5'h0, rom_wr_en, rom_addr, rom_wdata}, {5'h0, 1'b1, 18'h1_0000, 8'hc3});
      poll(NASC_ROM_WR, q);
      chk(q, 32'h0100_00c3);
      $display("test rom port done");
   endtask
   task automatic t_led;
      four_led_mode <= 1'b1;
      wr(NASC_OFS_ROM, 32'h8100_0000);
      cyc(4);
      chk({30'h0, rom_address_bit16, led_fd_col}, 32'h2);
      wr(NASC_OFS_ROM, 32'h0100_0000);
      cyc(4);
      chk({30'h0, rom_address_bit16, led_fd_col}, 32'h1);
      four_led_mode <= 1'b0;
      wr(NASC_OFS_ROM, 32'h8100_0000);
      cyc(4);
      chk({30'h0, rom_address_bit16, led_fd_col}, 32'h1);
      $display("test led pin done");
   endtask
   task automatic t_burst;
      wr(NASC_OFS_BURST, 32'h0003_0000);
      n_done = 0;
      repeat (7) begin
         tx_ok <= 1'b1;
         cyc(4);
         tx_ok <= 1'b0;
         cyc(4);
      end
      chk(n_done, 32'h2);
      $display("test burst done");
   endtask
   task automatic t_timeout;
      int n;
      int d;
      wr(NASC_OFS_BURST, 32'hffff_ffff);
      rd(NASC_OFS_BURST, 32'h001f_0fff);
      wr(NASC_OFS_IRQEN, 32'h1000_0000);
      rd(NASC_OFS_IRQEN, 32'h1000_0000);
      wr(NASC_OFS_BURST, 32'h0000_0003);
      tx_start <= 1'b1;
      cyc(100);
      restart(n);
      chk({31'h0, n >= 3 * T10 - 5 && n <= 4 * T10 + 15}, 32'h1);
      wr(NASC_OFS_BURST, 32'h0000_0001);
      speed_100 <= 1'b1;
      restart(n);
      chk({31'h0, n >= 125 && n <= 265}, 32'h1);
      wr(NASC_OFS_IRQEN, 32'h0);
      speed_100 <= 1'b0;
      d = n_defer;
      restart(n);
      chk(n_defer, d);
      $display("test time-out done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #200_000;
      n_mismatch++;
      close_out;
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_desc;
      t_station;
      t_rom;
      t_led;
      t_burst;
      t_timeout;
      close_out;
   end
endmodule

// [verilog/nasc_csr.sv]
// Top: aux status/config register bank on AHB-Lite
`timescale 1ns/1ps
module nasc_csr #(
   parameter int TICK10_CYC = nasc_pkg::NASC_TICK10_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [31:0] tx_desc_ptr_now,
   input  wire logic [31:0] rx_desc_ptr_now,
   input  wire logic [2:0]  rx_state,
   input  wire logic        tx_ok,
   input  wire logic        tx_start,
   input  wire logic        speed_100,
   input  wire logic        four_led_mode,
   input  wire logic        ee_valid,
   input  wire logic [47:0] ee_station,
   input  wire logic [7:0]  rom_rdata,
   output logic      [17:0] rom_addr,
   output logic      [7:0]  rom_wdata,
   output logic             rom_rd_en,
   output logic             rom_wr_en,
   output logic             rom_address_bit16,
   output logic             led_fd_col,
   output logic             tx_done_irq,
   output logic             tx_defer_irq
);
   import nasc_pkg::*;
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      NASC_ROM_IDLE = 3'b001,
      NASC_ROM_RD_S = 3'b010,
      NASC_ROM_WR_S = 3'b100
   } nasc_rom_t;
   nasc_rom_t   rom_st_q;
   logic [31:0] rom_q;
   logic [31:0] sta_lo_q;
   logic [15:0] sta_hi_q;
   logic [31:0] burst_q;
   logic [31:0] irqen_q;
   logic [4:0]  bcnt_q;
   logic [11:0] tmr_q;
   logic        armed_q;
   logic        ee_done_q;
   logic [2:0]  rwait_q;
   logic        wr_ph_q;
   logic [7:0]  wa_q;
   logic [2:0]  rxs_s1_q, rxs_q;
   logic        txok_s1_q, txok_q, txok_p_q;
   logic        txst_s1_q, txst_q, txst_p_q;
   logic        spd_s1_q, spd_q, led_s1_q, led_q, eev_s1_q, eev_q;
   logic [31:0] wtd_s1_q, wtd_q, wrd_s1_q, wrd_q;
   logic [7:0]  romd_s1_q, romd_q;
   logic [31:0] hrdata_q;
   logic        done_q, defer_q, pin_a16_q, pin_led_q;
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rxs_s1_q, rxs_q, txok_s1_q, txok_q, txok_p_q} <= '0;
         {txst_s1_q, txst_q, txst_p_q, spd_s1_q, spd_q} <= '0;
         {led_s1_q, led_q, eev_s1_q, eev_q}             <= '0;
         {wtd_s1_q, wtd_q, wrd_s1_q, wrd_q}             <= '0;
         {romd_s1_q, romd_q}                            <= '0;
      end else begin
         rxs_s1_q  <= rx_state;
         rxs_q     <= rxs_s1_q;
         txok_s1_q <= tx_ok;
         txok_q    <= txok_s1_q;
         txok_p_q  <= txok_q;
         txst_s1_q <= tx_start;
         txst_q    <= txst_s1_q;
         txst_p_q  <= txst_q;
         spd_s1_q  <= speed_100;
         spd_q     <= spd_s1_q;
         led_s1_q  <= four_led_mode;
         led_q     <= led_s1_q;
         eev_s1_q  <= ee_valid;
         eev_q     <= eev_s1_q;
         wtd_s1_q  <= tx_desc_ptr_now;
         wtd_q     <= wtd_s1_q;
         wrd_s1_q  <= rx_desc_ptr_now;
         wrd_q     <= wrd_s1_q;
         romd_s1_q <= rom_rdata;
         romd_q    <= romd_s1_q;
      end
   end
   wire tx_ok_rise    = txok_q && !txok_p_q;
   wire tx_start_rise = txst_q && !txst_p_q;
   // ----------------------------------------------------------------
   // AHB-Lite decode
   // ----------------------------------------------------------------
   wire       a_valid  = hsel && hready && htrans[1];
   wire       do_write = wr_ph_q;
   wire       rx_stop  = (rxs_q == NASC_RX_STOPPED);
   wire       sta_wok  = rx_stop && ee_done_q;
   wire       w_burst  = do_write && (wa_q == NASC_OFS_BURST);
   wire       w_rom    = do_write && (wa_q == NASC_OFS_ROM) && (rom_st_q == NASC_ROM_IDLE);
   wire       w_sta_lo = do_write && (wa_q == NASC_OFS_STA_LO) && sta_wok;
   wire       w_sta_hi = do_write && (wa_q == NASC_OFS_STA_HI) && sta_wok;
   wire       w_irqen  = do_write && (wa_q == NASC_OFS_IRQEN);
   wire [7:0] ra       = haddr[7:0];
   wire [31:0] rd_mux =
      (ra == NASC_OFS_TXDESC) ? wtd_q :
      (ra == NASC_OFS_RXDESC) ? wrd_q :
      (ra == NASC_OFS_BURST)  ? burst_q :
      (ra == NASC_OFS_ROM)    ? rom_q :
      (ra == NASC_OFS_STA_LO) ? sta_lo_q :
      (ra == NASC_OFS_STA_HI) ? {16'h0000, sta_hi_q} :
      (ra == NASC_OFS_IRQEN)  ? irqen_q :
      (ra == NASC_OFS_EVENTS) ? {30'h0, defer_q, done_q} : NASC_ZERO;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_q  <= 1'b0;
         wa_q     <= 8'h00;
         hrdata_q <= NASC_ZERO;
      end else begin
         wr_ph_q  <= a_valid && hwrite;
         wa_q     <= haddr[7:0];
         if (a_valid && !hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end
   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   // ----------------------------------------------------------------
   // Station address
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sta_lo_q  <= NASC_ZERO;
         sta_hi_q  <= 16'h0000;
         ee_done_q <= 1'b0;
      end else if (!ee_done_q) begin
         if (eev_q) begin
            sta_lo_q  <= ee_station[31:0];
            sta_hi_q  <= ee_station[47:32];
            ee_done_q <= 1'b1;
         end
      end else begin
         if (w_sta_lo) begin
            sta_lo_q <= hwdata;
         end
         if (w_sta_hi) begin
            sta_hi_q <= hwdata[15:0];
         end
      end
   end
   // ----------------------------------------------------------------
   // Burst count and time-out
   // ----------------------------------------------------------------
   nasc_tick_if tk ();
   assign tk.run  = irqen_q[NASC_DEFIE] && armed_q;
   assign tk.fast = spd_q;
   nasc_tick_div #(.TICK10_CYC(TICK10_CYC)) u_div (
      .hclk    (hclk),
      .hresetn (hresetn),
      .t       (tk)
   );
   wire [4:0]  bcnt_set = burst_q[NASC_BCNT_MSB:NASC_BCNT_LSB];
   wire [11:0] tto_set  = burst_q[NASC_TTO_MSB:0];
   wire        bhit     = tx_ok_rise && (bcnt_q + 5'h01 == bcnt_set);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         burst_q <= NASC_BURST_RESET;
         irqen_q <= NASC_ZERO;
         bcnt_q  <= 5'h00;
         tmr_q   <= 12'h000;
         armed_q <= 1'b0;
         done_q  <= 1'b0;
         defer_q <= 1'b0;
      end else begin
         if (w_burst) begin
            burst_q <= {11'h000, hwdata[NASC_BCNT_MSB:NASC_BCNT_LSB], 4'h0,
                        hwdata[NASC_TTO_MSB:0]};
         end
         if (w_irqen) begin
            irqen_q <= hwdata;
         end
         if (tx_ok_rise) begin
            bcnt_q <= bhit ? 5'h00 : bcnt_q + 5'h01;
         end
         done_q <= bhit;
         defer_q <= 1'b0;
         if (tx_start_rise) begin
            tmr_q   <= tto_set;
            armed_q <= 1'b1;
         end else if (tk.tick) begin
            if (tmr_q == 12'h000) begin
               defer_q <= 1'b1;
               armed_q <= 1'b0;
            end else begin
               tmr_q <= tmr_q - 12'h001;
            end
         end
      end
   end
   assign tx_done_irq  = done_q;
   assign tx_defer_irq = defer_q;
   // ----------------------------------------------------------------
   // Boot ROM port
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rom_q     <= NASC_ROM_RESET;
         rom_st_q  <= NASC_ROM_IDLE;
         rwait_q   <= 3'h0;
         pin_a16_q <= 1'b0;
         pin_led_q <= 1'b0;
      end else begin
         pin_a16_q <= led_q && rom_q[NASC_ROM_SEL] && rom_q[NASC_ROM_ALSB + 16];
         pin_led_q <= !(led_q && rom_q[NASC_ROM_SEL]);
         unique case (rom_st_q)
            NASC_ROM_IDLE: begin
               if (w_rom) begin
                  rom_q <= {hwdata[NASC_ROM_SEL], 3'h0,
                            hwdata[NASC_ROM_RD:NASC_ROM_ALSB],
                            hwdata[NASC_ROM_DMSB:0]};
                  rwait_q <= 3'h0;
                  if (hwdata[NASC_ROM_RD]) begin
                     rom_st_q <= NASC_ROM_RD_S;
                  end else if (hwdata[NASC_ROM_WR]) begin
                     rom_st_q <= NASC_ROM_WR_S;
                  end
               end
            end
            NASC_ROM_RD_S: begin
               rwait_q <= rwait_q + 3'h1;
               if (rwait_q == 3'(NASC_ROM_WAIT_CYC)) begin
                  rom_q[NASC_ROM_DMSB:0] <= romd_q;
                  rom_q[NASC_ROM_RD]     <= 1'b0;
                  rom_q[NASC_ROM_WR]     <= 1'b0;
                  rom_st_q               <= NASC_ROM_IDLE;
               end
            end
            NASC_ROM_WR_S: begin
               rwait_q <= rwait_q + 3'h1;
               if (rwait_q == 3'(NASC_ROM_WAIT_CYC)) begin
                  rom_q[NASC_ROM_WR] <= 1'b0;
                  rom_st_q           <= NASC_ROM_IDLE;
               end
            end
         endcase
      end
   end
   assign rom_addr          = rom_q[NASC_ROM_AMSB:NASC_ROM_ALSB];
   assign rom_wdata         = rom_q[NASC_ROM_DMSB:0];
   assign rom_rd_en         = rom_q[NASC_ROM_RD];
   assign rom_wr_en         = rom_q[NASC_ROM_WR];
   assign rom_address_bit16 = pin_a16_q;
   assign led_fd_col        = pin_led_q;
endmodule

// [verilog/nasc_pkg.sv]
// Package: offsets, fields, reset values and timing for the aux status/config CSRs
// Functional notes
// - A read-only word shows the transmit descriptor address now in work.
// - A read-only word shows the receive descriptor address now in work.
// - Successful transmissions are counted and each time the count meets the burst value a transmit-done interrupt pulses, repeating.
// - The twelve-bit time-out value is the allowed deferral plus back-off before the next transmission.
// - With the deferral interrupt enable set, the timer steps down every 2.56 us at 100M or 25.6 us at 10M.
// - If the timer expires before the next transmission starts, the deferral interrupt is raised.
// - The ROM address-16 select only acts in four-LED mode, choosing address bit 16 over the duplex/collision LED.
// - Setting the read strobe starts a ROM read and the device clears it once the byte is in the data field.
// - Setting the write strobe starts a ROM write and the device clears it when the write is done.
// - The ROM port has an eighteen-bit byte address and an eight-bit data field.
// - After reset both station address words load from the serial EEPROM.
// - Station address bytes 0-3 fill the low word from bit 0 up, bytes 4-5 the low half of the high word, the rest reserved.
// - Station address words always read and are written only while receive state is stopped.
package nasc_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] NASC_OFS_TXDESC = 8'h94;
   localparam logic [7:0] NASC_OFS_RXDESC = 8'h98;
   localparam logic [7:0] NASC_OFS_BURST  = 8'h9c;
   localparam logic [7:0] NASC_OFS_ROM    = 8'ha0;
   localparam logic [7:0] NASC_OFS_STA_LO = 8'ha4;
   localparam logic [7:0] NASC_OFS_STA_HI = 8'ha8;
   localparam logic [7:0] NASC_OFS_IRQEN  = 8'hc0;
   localparam logic [7:0] NASC_OFS_EVENTS = 8'hc4;
   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int NASC_BCNT_LSB = 16;
   localparam int NASC_BCNT_MSB = 20;
   localparam int NASC_TTO_MSB  = 11;
   localparam int NASC_ROM_SEL  = 31;
   localparam int NASC_ROM_RD   = 27;
   localparam int NASC_ROM_WR   = 26;
   localparam int NASC_ROM_AMSB = 25;
   localparam int NASC_ROM_ALSB = 8;
   localparam int NASC_ROM_DMSB = 7;
   localparam int NASC_DEFIE    = 28;
   localparam logic [2:0] NASC_RX_STOPPED = 3'h0;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] NASC_ROM_RESET   = 32'h8000_0000;
   localparam logic [31:0] NASC_BURST_RESET = 32'h0000_0000;
   localparam logic [31:0] NASC_ZERO        = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int NASC_CLK_MHZ      = 50;
   localparam int NASC_TICK100_NS   = 2560;
   localparam int NASC_TICK10_NS    = 25600;
   localparam int NASC_TICK100_CYC  = NASC_TICK100_NS * NASC_CLK_MHZ / 1000;
   localparam int NASC_TICK10_CYC   = NASC_TICK10_NS * NASC_CLK_MHZ / 1000;
   localparam int NASC_ROM_WAIT_CYC = 4;
endpackage

// [verilog/nasc_tick_div.sv]
// Timer tick divider for the transmit time-out
`timescale 1ns/1ps
module nasc_tick_div #(
   parameter int TICK10_CYC = nasc_pkg::NASC_TICK10_CYC
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   nasc_tick_if.div  t
);
   import nasc_pkg::*;
   logic [15:0] cnt_q;
   logic        tick_q;
   wire  [15:0] lim = t.fast ? 16'(NASC_TICK100_CYC - 1) : 16'(TICK10_CYC - 1);
   wire         hit = (cnt_q >= lim);
   assign t.tick = tick_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= (!t.run || hit) ? 16'h0000 : cnt_q + 16'h0001;
         tick_q <= t.run && hit;
      end
   end
endmodule

// [verilog/nasc_tick_if.sv]
// Interface: tick divider control and pulse
`timescale 1ns/1ps
interface nasc_tick_if;
   logic run;
   logic fast;
   logic tick;
   modport div  (input run, input fast, output tick);
   modport user (output run, output fast, input tick);
endinterface
